// ---- hdl/hwpm_defs.svh ----
// Purpose: offsets, field positions, reset values and timing counts of the host window
// Assumes: 100 MHz system clock on both ends
// Notes:   definitions only
`ifndef HWPM_DEFS_SVH
`define HWPM_DEFS_SVH

// window geometry
`define HWPM_ADDR_W          13
`define HWPM_DATA_W          16
`define HWPM_BOOT_WORDS      512

// register offsets, window relative
`define HWPM_OFF_CHIP_ID     13'h1000
`define HWPM_OFF_DELAY_DUMMY 13'h1002
`define HWPM_OFF_BYTE_SWAP   13'h1008
`define HWPM_OFF_CASCADE_SEL 13'h100A
`define HWPM_OFF_MODE_CTRL   13'h100C
`define HWPM_OFF_CONFIG      13'h100E
`define HWPM_OFF_INT_CTRL    13'h1010
`define HWPM_OFF_OUT_CTRL    13'h1014
`define HWPM_OFF_MODE_CONF   13'h1072
`define HWPM_OFF_CHIP_ID_CHK 13'h1074

// mode control and byte swap fields
`define HWPM_MC_WREN_BIT     2
`define HWPM_MC_BDET_BIT     3
`define HWPM_MC_RSTLAT_BIT   4
`define HWPM_SWAP_LO_BIT     0
`define HWPM_SWAP_HI_BIT     8

// reset values seen on leaving reset mode
`define HWPM_RST_REG8        8'h00
`define HWPM_RST_SWAP        1'b0

// timing
`define HWPM_CLK_PERIOD_NS   10
`define HWPM_EXIT_TIME_NS    3000
`define HWPM_EXIT_CYCLES     ((`HWPM_EXIT_TIME_NS + `HWPM_CLK_PERIOD_NS - 1) / `HWPM_CLK_PERIOD_NS)

`endif

// ---- hdl/hwpm_pkg.sv ----
// Purpose: shared types of the host window
// Assumes: nothing
// Notes:   mode codes match the two-bit mode field
`default_nettype none
package hwpm_pkg;
  typedef enum logic [1:0] {
    HWPM_MODE_RESET  = 2'h0,
    HWPM_MODE_NORMAL = 2'h1,
    HWPM_MODE_DEEP   = 2'h2
  } hwpm_mode_t;

  typedef enum logic [2:0] {
    HWPM_H_IDLE   = 3'h0,
    HWPM_H_SETUP  = 3'h1,
    HWPM_H_STROBE = 3'h3,
    HWPM_H_HOLD   = 3'h2,
    HWPM_H_GAP    = 3'h6
  } hwpm_host_state_t;
endpackage
`default_nettype wire

// ---- hdl/hwpm_bus_if.sv ----
// Purpose: asynchronous parallel pins between host and device
// Assumes: data bus resolved from the two enables, idle level all ones
// Notes:   no clocking; both ends sample through their own synchronisers
`include "hwpm_defs.svh"
`default_nettype none
interface hwpm_bus_if;
  logic                      chipSelectN;
  logic                      writeStrobeN;
  logic                      readStrobeN;
  logic [`HWPM_ADDR_W-1:0]   addr;
  logic [`HWPM_DATA_W-1:0]   hostDataOut;
  logic                      hostDataOe;
  logic [`HWPM_DATA_W-1:0]   devDataOut;
  logic                      devDataOe;
  logic                      hardResetInN;
  logic                      bootLoadBusyN;
  logic [`HWPM_DATA_W-1:0]   busData;

  // contention shows as the device value; idle bus floats high
  assign busData = devDataOe ? devDataOut : (hostDataOe ? hostDataOut : 16'hFFFF);

  modport device (input chipSelectN, writeStrobeN, readStrobeN, addr, busData, hardResetInN,
                  output devDataOut, devDataOe, bootLoadBusyN);
  modport host   (output chipSelectN, writeStrobeN, readStrobeN, addr, hostDataOut, hostDataOe,
                  hardResetInN, input busData, bootLoadBusyN);
endinterface
`default_nettype wire

// ---- hdl/hwpm_device.sv ----
// Purpose: device end of the host window: decode, registers, mode and deep sleep control
// Assumes: host strobes last several clocks; all pins pass two flip-flops first
// Notes:   a write is taken when the write cycle ends, a read is served while it lasts
`include "hwpm_defs.svh"
`default_nettype none
module hwpm_device #(
  parameter int unsigned BOOT_LOAD_CYCLES = 64,
  parameter logic [7:0]  CHIP_ID          = 8'h3C  // arbitrary value
) (
  // system
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // host pins
  hwpm_bus_if.device       bus,
  // user side
  output logic [1:0]       opMode,
  output logic             swapEnable,
  output logic [1:0]       cascadeSelect,
  output logic [7:0]       configuration,
  output logic [7:0]       interruptControl,
  output logic [7:0]       outputControl
);
  initial begin
    if (BOOT_LOAD_CYCLES < 1 || BOOT_LOAD_CYCLES > 65535) $error("bad BOOT_LOAD_CYCLES");
  end

  localparam int unsigned PW = 4 + `HWPM_ADDR_W + `HWPM_DATA_W;
  localparam logic [8:0]  EXIT_CNT = 9'(`HWPM_EXIT_CYCLES);

  // pin synchroniser: stage one is read by stage two only
  logic [PW-1:0] pinSync1_q;
  logic [PW-1:0] pinSync2_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pinSync1_q <= '1;
      pinSync2_q <= '1;
    end else begin
      pinSync1_q <= {bus.hardResetInN, bus.chipSelectN, bus.writeStrobeN, bus.readStrobeN,
                     bus.addr, bus.busData};
      pinSync2_q <= pinSync1_q;
    end
  end

  wire                     hardRstN = pinSync2_q[PW-1];
  wire                     csN      = pinSync2_q[PW-2];
  wire                     weN      = pinSync2_q[PW-3];
  wire                     oeN      = pinSync2_q[PW-4];
  wire [`HWPM_ADDR_W-1:0]  pinAddr  = pinSync2_q[`HWPM_DATA_W +: `HWPM_ADDR_W];
  wire [`HWPM_DATA_W-1:0]  pinData  = pinSync2_q[`HWPM_DATA_W-1:0];

  wire wrNow = !csN && !weN;
  wire rdNow = !csN && !oeN;

  // state
  hwpm_pkg::hwpm_mode_t    mode_q;
  logic                    wrPrev_q, rdPrev_q;
  logic [`HWPM_ADDR_W-1:0] wrAddr_q;
  logic [`HWPM_DATA_W-1:0] wrData_q;
  logic                    pend_q;
  logic [7:0]              pendVal_q;
  logic [8:0]              exitCnt_q;
  logic [15:0]             bootCnt_q;
  logic                    busyN_q;
  logic                    swapLo_q, swapHi_q, bdet_q, rstLat_q;
  logic                    swapEn_q;
  logic [1:0]              cascade_q;
  logic [7:0]              config_q, intCtrl_q, outCtrl_q;
  logic [`HWPM_DATA_W-1:0] rdData_q;
  logic                    rdOe_q;
  logic [`HWPM_DATA_W-1:0] bootMem [`HWPM_BOOT_WORDS];

  wire busy      = !busyN_q;
  wire isNormal  = mode_q == hwpm_pkg::HWPM_MODE_NORMAL;
  wire isReset   = mode_q == hwpm_pkg::HWPM_MODE_RESET;
  wire isDeep    = mode_q == hwpm_pkg::HWPM_MODE_DEEP;
  wire swapOn    = swapLo_q && swapHi_q;
  wire wrDone    = wrPrev_q && !wrNow && !busy;
  wire rdStart   = rdNow && !rdPrev_q && !busy;

  // write decode on the captured address
  wire [1:0] wrSect   = wrAddr_q[12:11];
  wire       wrBoot   = wrSect == 2'h0 || wrSect == 2'h3;
  wire       wrCtrl   = wrAddr_q == `HWPM_OFF_MODE_CTRL;
  wire       wrConf   = wrAddr_q == `HWPM_OFF_MODE_CONF;
  wire       wrDummy  = wrAddr_q == `HWPM_OFF_DELAY_DUMMY;
  wire [15:0] wd      = swapOn ? {wrData_q[7:0], wrData_q[15:8]} : wrData_q;
  wire       confOk   = pend_q && (wd[7:0] == ~pendVal_q);
  wire       applyPair = wrDone && !isDeep && wrConf && confOk;
  // reset mode keeps only the mode pair; deep sleep drops everything here
  wire       plainWr  = wrDone && isNormal && !wrCtrl && !wrConf;
  wire       regWr    = plainWr && !wrBoot;

  // read decode on the live address
  wire [1:0] rdSect   = pinAddr[12:11];
  wire       rdBoot   = rdSect == 2'h0 || rdSect == 2'h3;
  logic [15:0] regVal;
  always_comb begin
    regVal = 16'h0000;  // unmapped and reserved-zero bits read zero
    // no bit in this register set is reserved-one, so none is forced high
    unique case (pinAddr)
      `HWPM_OFF_CHIP_ID:     regVal = {8'h00, CHIP_ID};
      `HWPM_OFF_CHIP_ID_CHK: regVal = {8'h00, ~CHIP_ID};
      `HWPM_OFF_BYTE_SWAP:   regVal = {7'h00, swapHi_q, 7'h00, swapLo_q};
      `HWPM_OFF_CASCADE_SEL: regVal = {14'h0000, cascade_q};
      // write-enable bit reads zero; the eleven plain reserved bits are given zero too
      `HWPM_OFF_MODE_CTRL:   regVal = {11'h000, rstLat_q, bdet_q, 1'b0, mode_q};
      `HWPM_OFF_CONFIG:      regVal = {8'h00, config_q};
      `HWPM_OFF_INT_CTRL:    regVal = {8'h00, intCtrl_q};
      `HWPM_OFF_OUT_CTRL:    regVal = {8'h00, outCtrl_q};
      default:               regVal = 16'h0000;
    endcase
  end
  wire [15:0] rawRead = rdBoot ? bootMem[pinAddr[9:1]] :
                        (isReset ? 16'h0000 : regVal);
  wire [15:0] rdSwap  = swapOn ? {rawRead[7:0], rawRead[15:8]} : rawRead;

  // pin edge tracking and write capture
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wrPrev_q <= 1'b0;
      rdPrev_q <= 1'b0;
      wrAddr_q <= '0;
      wrData_q <= '0;
    end else begin
      wrPrev_q <= wrNow;
      rdPrev_q <= rdNow;
      if (wrNow) begin
        wrAddr_q <= pinAddr;
        wrData_q <= pinData;
      end
    end
  end

  // boot load busy after a hard reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bootCnt_q <= 16'(BOOT_LOAD_CYCLES);
      busyN_q   <= 1'b0;
    end else if (!hardRstN) begin
      bootCnt_q <= 16'(BOOT_LOAD_CYCLES);
      busyN_q   <= 1'b0;
    end else if (bootCnt_q != 16'h0000) begin
      bootCnt_q <= bootCnt_q - 16'h0001;
      busyN_q   <= bootCnt_q == 16'h0001;
    end
  end

  // mode, confirmation pair and deep sleep exit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_q    <= hwpm_pkg::HWPM_MODE_RESET;
      pend_q    <= 1'b0;
      pendVal_q <= 8'h00;
      exitCnt_q <= 9'h000;
      bdet_q    <= 1'b0;
      rstLat_q  <= 1'b1;
    end else if (!hardRstN) begin
      mode_q    <= hwpm_pkg::HWPM_MODE_RESET;
      pend_q    <= 1'b0;
      exitCnt_q <= 9'h000;
      rstLat_q  <= 1'b1;
    end else if (isDeep) begin
      // only the delay dummy write is seen, and only as a wake request
      if (wrDone && wrDummy && exitCnt_q == 9'h000) begin
        exitCnt_q <= EXIT_CNT;
      end else if (exitCnt_q != 9'h000) begin
        exitCnt_q <= exitCnt_q - 9'h001;
        if (exitCnt_q == 9'h001) begin
          mode_q <= hwpm_pkg::HWPM_MODE_NORMAL;
        end
      end
    end else begin
      if (wrDone && wrCtrl) begin
        pend_q    <= 1'b1;
        pendVal_q <= wd[7:0];
      end else if (wrDone || (rdStart && !rdBoot)) begin
        pend_q <= 1'b0;  // any write, or a read outside the boot block, between the pair breaks it
      end
      if (applyPair) begin
        if (pendVal_q[`HWPM_MC_WREN_BIT] && pendVal_q[1:0] != 2'h3) begin
          mode_q <= hwpm_pkg::hwpm_mode_t'(pendVal_q[1:0]);
        end
        if (pendVal_q[`HWPM_MC_BDET_BIT]) begin
          bdet_q <= 1'b0;
        end
        if (pendVal_q[`HWPM_MC_RSTLAT_BIT]) begin
          rstLat_q <= 1'b0;
        end
      end
    end
  end

  // software registers; untouched across deep sleep
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      swapEn_q  <= `HWPM_RST_SWAP;
      swapLo_q  <= `HWPM_RST_SWAP;
      swapHi_q  <= `HWPM_RST_SWAP;
      cascade_q <= 2'h0;
      config_q  <= `HWPM_RST_REG8;
      intCtrl_q <= `HWPM_RST_REG8;
      outCtrl_q <= `HWPM_RST_REG8;
    end else if (!hardRstN) begin
      swapEn_q  <= `HWPM_RST_SWAP;
      swapLo_q  <= `HWPM_RST_SWAP;
      swapHi_q  <= `HWPM_RST_SWAP;
      cascade_q <= 2'h0;
      config_q  <= `HWPM_RST_REG8;
      intCtrl_q <= `HWPM_RST_REG8;
      outCtrl_q <= `HWPM_RST_REG8;
    end else if (regWr) begin
      unique case (wrAddr_q)
        `HWPM_OFF_BYTE_SWAP: begin
          swapLo_q <= wd[`HWPM_SWAP_LO_BIT];
          swapHi_q <= wd[`HWPM_SWAP_HI_BIT];
          swapEn_q <= wd[`HWPM_SWAP_LO_BIT] & wd[`HWPM_SWAP_HI_BIT];
        end
        `HWPM_OFF_CASCADE_SEL: cascade_q <= wd[1:0];
        `HWPM_OFF_CONFIG:      config_q  <= wd[7:0];
        `HWPM_OFF_INT_CTRL:    intCtrl_q <= wd[7:0];
        `HWPM_OFF_OUT_CTRL:    outCtrl_q <= wd[7:0];
        default: ;
      endcase
    end
  end

  // boot block: a write in normal mode fills the word under any of its four aliases
  always_ff @(posedge clk_sys) begin
    if (plainWr && wrBoot) begin
      bootMem[wrAddr_q[9:1]] <= wd;
    end
  end

  // read drive; never while busy or asleep
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdOe_q   <= 1'b0;
      rdData_q <= 16'h0000;
    end else begin
      rdOe_q   <= rdNow && !busy && !isDeep && hardRstN;
      rdData_q <= rdSwap;
    end
  end

  assign bus.devDataOut     = rdData_q;
  assign bus.devDataOe      = rdOe_q;
  assign bus.bootLoadBusyN  = busyN_q;
  assign opMode             = mode_q;
  assign swapEnable         = swapEn_q;
  assign cascadeSelect      = cascade_q;
  assign configuration      = config_q;
  assign interruptControl   = intCtrl_q;
  assign outputControl      = outCtrl_q;
endmodule // hwpm_device
`default_nettype wire

// ---- hdl/hwpm_host.sv ----
// Purpose: host end: turns user commands into pin cycles, pulses the hard reset
// Assumes: device synchronises pins, so each strobe is held many clocks
// Notes:   ordering of mode pairs is left to the user side
`include "hwpm_defs.svh"
`default_nettype none
module hwpm_host #(
  parameter int unsigned STROBE_CYCLES      = 8,
  parameter int unsigned GAP_CYCLES         = 4,
  parameter int unsigned RESET_PULSE_CYCLES = 8
) (
  // system
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  // pins
  hwpm_bus_if.host                      bus,
  // command
  input  wire logic                     cmdValid,
  input  wire logic                     cmdWrite,
  input  wire logic [`HWPM_ADDR_W-1:0]  cmdAddr,
  input  wire logic [`HWPM_DATA_W-1:0]  cmdWdata,
  output logic                          cmdReady,
  // answer
  output logic                          rspValid,
  output logic [`HWPM_DATA_W-1:0]       rspData,
  // reset and status
  input  wire logic                     resetReq,
  output logic                          deviceBusy
);
  initial begin
    if (STROBE_CYCLES < 6 || STROBE_CYCLES > 255 || GAP_CYCLES < 1 || GAP_CYCLES > 255 ||
        RESET_PULSE_CYCLES < 3 || RESET_PULSE_CYCLES > 255) $error("bad host timing");
  end

  hwpm_pkg::hwpm_host_state_t state_q;
  logic [7:0]               cnt_q;
  logic [7:0]               rstCnt_q;
  logic                     isWrite_q, csN_q, weN_q, oeN_q, dataOe_q, rstN_q;
  logic [`HWPM_ADDR_W-1:0]  addr_q;
  logic [`HWPM_DATA_W-1:0]  wdata_q, rsp_q;
  logic                     rspValid_q, ready_q, busy_q;
  logic [16:0]              inSync1_q, inSync2_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // busy bit resets to busy so no false ready shows right after reset
      inSync1_q <= {1'b0, 16'hFFFF};
      inSync2_q <= {1'b0, 16'hFFFF};
    end else begin
      inSync1_q <= {bus.bootLoadBusyN, bus.busData};
      inSync2_q <= inSync1_q;
    end
  end

  wire idle  = state_q == hwpm_pkg::HWPM_H_IDLE;
  wire take  = idle && cmdValid && ready_q;
  wire cntHit = cnt_q == 8'h00;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= hwpm_pkg::HWPM_H_IDLE;
      cnt_q <= 8'h00;
      rstCnt_q <= 8'h00;
      isWrite_q <= 1'b0;
      {csN_q, weN_q, oeN_q, rstN_q} <= 4'hF;
      dataOe_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
      rsp_q <= '0;
      rspValid_q <= 1'b0;
      ready_q <= 1'b0;
      busy_q <= 1'b1;
    end else begin
      busy_q     <= !inSync2_q[16];
      rspValid_q <= 1'b0;
      ready_q    <= idle && !take && rstCnt_q == 8'h00 && !resetReq;
      if (resetReq && idle) begin
        rstCnt_q <= 8'(RESET_PULSE_CYCLES);
        rstN_q   <= 1'b0;
      end else if (rstCnt_q != 8'h00) begin
        rstCnt_q <= rstCnt_q - 8'h01;
        rstN_q   <= rstCnt_q == 8'h01;
      end
      unique case (state_q)
        hwpm_pkg::HWPM_H_IDLE: if (take) begin
          state_q   <= hwpm_pkg::HWPM_H_SETUP;
          isWrite_q <= cmdWrite;
          addr_q    <= cmdAddr;
          wdata_q   <= cmdWdata;
          dataOe_q  <= cmdWrite;
          csN_q     <= 1'b0;
        end
        hwpm_pkg::HWPM_H_SETUP: begin
          state_q <= hwpm_pkg::HWPM_H_STROBE;
          cnt_q   <= 8'(STROBE_CYCLES - 1);
          weN_q   <= !isWrite_q;
          oeN_q   <= isWrite_q;
        end
        hwpm_pkg::HWPM_H_STROBE: if (cntHit) begin
          state_q    <= hwpm_pkg::HWPM_H_HOLD;
          {weN_q, oeN_q} <= 2'h3;
          rsp_q      <= inSync2_q[15:0];
          rspValid_q <= !isWrite_q;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
        hwpm_pkg::HWPM_H_HOLD: begin
          state_q  <= hwpm_pkg::HWPM_H_GAP;
          cnt_q    <= 8'(GAP_CYCLES - 1);
          csN_q    <= 1'b1;  // pins fall back to negated, as sleep needs
          dataOe_q <= 1'b0;
        end
        hwpm_pkg::HWPM_H_GAP: if (cntHit) begin
          state_q <= hwpm_pkg::HWPM_H_IDLE;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
        default: state_q <= hwpm_pkg::HWPM_H_IDLE;
      endcase
    end
  end

  assign bus.chipSelectN  = csN_q;
  assign bus.writeStrobeN = weN_q;
  assign bus.readStrobeN  = oeN_q;
  assign bus.addr         = addr_q;
  assign bus.hostDataOut  = wdata_q;
  assign bus.hostDataOe   = dataOe_q;
  assign bus.hardResetInN = rstN_q;
  assign cmdReady         = ready_q;
  assign rspValid         = rspValid_q;
  assign rspData          = rsp_q;
  assign deviceBusy       = busy_q;
endmodule // hwpm_host
`default_nettype wire

// ---- verification/hwpm_asserts.sv ----
// Purpose: pin-level checks of the host window link
// Assumes: both ends are design modules, one clock
// Notes:   sees the shared interface and the device mode only
`include "hwpm_defs.svh"
`default_nettype none
module hwpm_asserts (
  // system
  input wire logic                    clk_sys,
  input wire logic                    rst_n,
  // pins
  input wire logic                    chipSelectN,
  input wire logic                    writeStrobeN,
  input wire logic                    readStrobeN,
  input wire logic [`HWPM_ADDR_W-1:0] addr,
  input wire logic                    hostDataOe,
  input wire logic                    devDataOe,
  input wire logic                    hardResetInN,
  input wire logic                    bootLoadBusyN,
  // device state
  input wire logic [1:0]              opMode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence sExitWrite;
    $rose(writeStrobeN) && addr == `HWPM_OFF_DELAY_DUMMY && opMode == 2'h2;
  endsequence
  // still asleep late in the 3us wait, then awake shortly after
  sequence sExitDone;
    ##295 (opMode == 2'h2) ##[1:20] (opMode == 2'h1);
  endsequence

  AST_BUSY_NO_DRIVE: assert property (!bootLoadBusyN |-> !devDataOe)
    else $error("data driven while busy");
  AST_DEEP_NO_DRIVE: assert property (opMode == 2'h2 |-> !devDataOe)
    else $error("data driven in deep sleep");
  AST_DRIVE_NEEDS_READ: assert property ($rose(devDataOe) |->
    !chipSelectN && !readStrobeN && $past(!readStrobeN))
    else $error("drive without read cycle");
  AST_NO_CONTENTION: assert property (!(hostDataOe && devDataOe))
    else $error("both ends drive data");
  AST_DEEP_ENTRY_IDLE: assert property ($rose(opMode == 2'h2) |->
    chipSelectN && writeStrobeN && readStrobeN)
    else $error("deep sleep entered with active pins");
  AST_MODE_LEGAL: assert property (opMode != 2'h3)
    else $error("illegal mode code");
  AST_EXIT_DELAY: assert property (sExitWrite |-> sExitDone)
    else $error("deep sleep exit time wrong");
  AST_HARD_RESET_BUSY: assert property ($fell(hardResetInN) |-> ##[1:6] !bootLoadBusyN)
    else $error("no busy after hard reset");
  AST_HARD_RESET_MODE: assert property ($fell(hardResetInN) |-> ##[1:6] opMode == 2'h0)
    else $error("hard reset left mode");
endmodule // hwpm_asserts
`default_nettype wire

// ---- verification/host_window_power_mode_control_tb.sv ----
// Purpose: self-checking bench of host and device ends joined by the pin interface
// Assumes: 100 MHz clock, short boot load count
// Notes:   device acts on a write about 12 clocks after the host takes it
`include "hwpm_defs.svh"
`default_nettype none
module host_window_power_mode_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CHIP_ID = 8'h3C; // arbitrary value

  logic                    clk_sys;
  logic                    rst_n;
  logic                    cmdValid;
  logic                    cmdWrite;
  logic [`HWPM_ADDR_W-1:0] cmdAddr;
  logic [`HWPM_DATA_W-1:0] cmdWdata;
  logic                    cmdReady;
  logic                    rspValid;
  logic [`HWPM_DATA_W-1:0] rspData;
  logic                    resetReq;
  logic                    deviceBusy;
  logic [1:0]              opMode;
  logic                    swapEnable;
  logic [1:0]              cascadeSelect;
  logic [7:0]              configuration;
  logic [7:0]              interruptControl;
  logic [7:0]              outputControl;
  logic [15:0]             rd;
  int                      miscompares;
  int                      total_checks;

  hwpm_bus_if hwpm_bus_if_i ();

  hwpm_device #(.BOOT_LOAD_CYCLES(4), .CHIP_ID(CHIP_ID)) hwpm_device_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus(hwpm_bus_if_i.device), .opMode(opMode),
    .swapEnable(swapEnable), .cascadeSelect(cascadeSelect), .configuration(configuration),
    .interruptControl(interruptControl), .outputControl(outputControl));

  hwpm_host hwpm_host_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus(hwpm_bus_if_i.host), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspData(rspData), .resetReq(resetReq), .deviceBusy(deviceBusy));

  hwpm_asserts hwpm_asserts_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .chipSelectN(hwpm_bus_if_i.chipSelectN),
    .writeStrobeN(hwpm_bus_if_i.writeStrobeN), .readStrobeN(hwpm_bus_if_i.readStrobeN),
    .addr(hwpm_bus_if_i.addr), .hostDataOe(hwpm_bus_if_i.hostDataOe),
    .devDataOe(hwpm_bus_if_i.devDataOe), .hardResetInN(hwpm_bus_if_i.hardResetInN),
    .bootLoadBusyN(hwpm_bus_if_i.bootLoadBusyN), .opMode(opMode));

  always #5 clk_sys = ~clk_sys;

  task automatic final_report();
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic waitv(ref logic s, input logic v, input int lim);
    int n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (s !== v && n < lim);
    if (s !== v) begin
      miscompares++;
      $display("[ERR] %0t wait ran out", $time);
      final_report();
    end
  endtask

  // request held from one edge to the edge that takes it
  task automatic xfer(input logic wr, input logic [12:0] a, input logic [15:0] wd);
    waitv(cmdReady, 1'b1, 200);
    @(posedge clk_sys);
    cmdValid <= 1'b1;
    cmdWrite <= wr;
    cmdAddr  <= a;
    cmdWdata <= wd;
    @(posedge clk_sys);
    cmdValid <= 1'b0;
    if (!wr) begin
      waitv(rspValid, 1'b1, 100);
      rd = rspData;
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [15:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [12:0] a, input logic [15:0] exp, input string what);
    xfer(1'b0, a, 16'h0000);
    chk(rd, exp, what);
  endtask

  task automatic settle();
    repeat (16) @(negedge clk_sys);
  endtask

  task automatic modepair(input logic [7:0] v);
    wr(`HWPM_OFF_MODE_CTRL, {8'h00, v});
    wr(`HWPM_OFF_MODE_CONF, {8'h00, ~v});
    settle();
  endtask

  task automatic t_reset_mode();
    rdchk(`HWPM_OFF_CHIP_ID, 16'h0000, "reset mode reg read");
    rdchk(13'h0800, 16'h0000, "section 1 start");
    rdchk(13'h17FE, 16'h0000, "section 2 end");
    wr(`HWPM_OFF_CONFIG, 16'h00A5);
    chk({14'h0000, opMode}, 16'h0000, "reset mode code");
  endtask

  task automatic t_normal_entry();
    wr(`HWPM_OFF_MODE_CTRL, 16'h0005);
    wr(`HWPM_OFF_OUT_CTRL, 16'h0011);
    wr(`HWPM_OFF_MODE_CONF, 16'h00FA);
    settle();
    chk({14'h0000, opMode}, 16'h0000, "split pair acted");
    modepair(8'h05);
    chk({14'h0000, opMode}, 16'h0001, "normal entry");
    chk({configuration, outputControl}, 16'h0000, "reset mode write kept");
    xfer(1'b0, `HWPM_OFF_MODE_CTRL, 16'h0000);
    chk(rd & 16'hFFEF, 16'h0001, "mode ctrl read");
  endtask

  task automatic t_regs();
    wr(`HWPM_OFF_CONFIG, 16'h00A5);
    wr(`HWPM_OFF_INT_CTRL, 16'h005A);
    wr(`HWPM_OFF_OUT_CTRL, 16'h00C3);
    rdchk(`HWPM_OFF_CONFIG, 16'h00A5, "config read");
    rdchk(`HWPM_OFF_INT_CTRL, 16'h005A, "int ctrl read");
    chk({interruptControl, outputControl}, 16'h5AC3, "register outputs");
    wr(`HWPM_OFF_CHIP_ID, 16'h0000);
    rdchk(`HWPM_OFF_CHIP_ID, {8'h00, CHIP_ID}, "id read");
    rdchk(`HWPM_OFF_CHIP_ID_CHK, {8'h00, ~CHIP_ID}, "id check read");
    wr(`HWPM_OFF_CASCADE_SEL, 16'hFF01);
    rdchk(`HWPM_OFF_CASCADE_SEL, 16'h0001, "reserved zero bits");
    chk({14'h0000, cascadeSelect}, 16'h0001, "cascade output");
    wr(`HWPM_OFF_BYTE_SWAP, 16'h0001);
    rdchk(`HWPM_OFF_BYTE_SWAP, 16'h0001, "swap low only");
    chk({15'h0000, swapEnable}, 16'h0000, "half swap enabled");
    wr(`HWPM_OFF_BYTE_SWAP, 16'h0101);
    rdchk(`HWPM_OFF_CONFIG, 16'hA500, "swapped read");
    chk({15'h0000, swapEnable}, 16'h0001, "swap enabled");
    wr(`HWPM_OFF_BYTE_SWAP, 16'h0000);
    rdchk(`HWPM_OFF_CONFIG, 16'h00A5, "unswapped read");
  endtask

  task automatic t_boot();
    logic [12:0] al[4] = '{13'h0010, 13'h0410, 13'h1810, 13'h1C10};
    wr(13'h0010, 16'h1234);
    foreach (al[i]) rdchk(al[i], 16'h1234, "boot alias");
  endtask

  task automatic t_deep();
    int n = 0;
    modepair(8'h06);
    chk({14'h0000, opMode}, 16'h0002, "deep entry");
    wr(`HWPM_OFF_CONFIG, 16'h00FF);
    settle();
    chk({8'h00, configuration}, 16'h00A5, "deep write acted");
    rdchk(`HWPM_OFF_CONFIG, 16'hFFFF, "deep read driven");
    wr(`HWPM_OFF_DELAY_DUMMY, 16'h0000);
    do begin
      @(negedge clk_sys);
      n++;
    end while (opMode !== 2'h1 && n < 400);
    chk({15'h0000, n >= 300 && n <= 330}, 16'h0001, "exit time");
    if (n >= 400) final_report();
    rdchk(`HWPM_OFF_CONFIG, 16'h00A5, "config after sleep");
    chk({interruptControl, outputControl}, 16'h5AC3, "regs after sleep");
  endtask

  task automatic t_hard_reset();
    modepair(8'h06);
    waitv(cmdReady, 1'b1, 200);
    @(posedge clk_sys);
    resetReq <= 1'b1;
    @(posedge clk_sys);
    resetReq <= 1'b0;
    waitv(deviceBusy, 1'b1, 50);
    waitv(deviceBusy, 1'b0, 200);
    chk({14'h0000, opMode}, 16'h0000, "hard reset mode");
    rdchk(`HWPM_OFF_INT_CTRL, 16'h0000, "reg read after hard reset");
    rdchk(13'h1C10, 16'h1234, "boot code after hard reset");
  endtask

  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdAddr = 13'h0000;
    cmdWdata = 16'h0000;
    resetReq = 1'b0;
    miscompares = 0;
    total_checks = 0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    waitv(deviceBusy, 1'b0, 200);
    t_reset_mode();
    t_normal_entry();
    t_regs();
    t_boot();
    t_deep();
    t_hard_reset();
    final_report();
  end
endmodule // host_window_power_mode_control_tb
`default_nettype wire
